// ===== shared/cfg_pkg.sv
package cfg_pkg;
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_CFG_ONE = 16'h2007;
  localparam logic [15:0] IDX_CFG_TWO = 16'h2008;
  localparam logic [15:0] IDX_OSC_CTRL = 16'h0010;
  localparam logic [15:0] IDX_OSC_TRIM = 16'h0011;
  localparam logic [15:0] IDX_PROG_CTRL = 16'h0012;
  localparam logic [15:0] IDX_SETTINGS = 16'h0013;
  localparam logic [15:0] CFG_ONE_RST = 16'h3fff;
  localparam logic [15:0] CFG_TWO_RST = 16'h3fff;
  localparam logic [15:0] CFG_ONE_FORCE1 = 16'h0880;
  localparam logic [15:0] CFG_TWO_FORCE1 = 16'h3fcf;
  localparam logic [15:0] CFG_IMPL_MASK = 16'h3fff;
  localparam logic [1:0] OSC_DIV_RST = 2'h2;
  localparam logic [5:0] OSC_TRIM_RST = 6'h00;
  localparam int DBG_BIT = 13;
  localparam int FAST_BIT = 12;
  localparam int BROWNOUT_LEVEL_FLAG_BIT = 10;
  localparam int BROWNOUT_POLICY_FIELD_HI = 9;
  localparam int BROWNOUT_POLICY_FIELD_LO = 8;
  localparam int LOCK_BIT = 6;
  localparam int HARD_RESET_PIN_BIT = 5;
  localparam int POWERUP_DELAY_TIMER_BIT = 4;
  localparam int WDT_BIT = 3;
  localparam int CAP_HI = 5;
  localparam int CAP_LO = 4;
  localparam int DIV_HI = 5;
  localparam int DIV_LO = 4;
  localparam int LOCKED_BIT = 3;
  localparam int STABLE_BIT = 2;
  localparam int PROG_EN_BIT = 0;
  localparam int SYNC_N = 8;
  localparam int SY_RST = 0;
  localparam int SY_POR = 1;
  localparam int SY_PIN = 2;
  localparam int SY_SLEEP = 3;
  localparam int SY_LOCK = 4;
  localparam int SY_STAB = 5;
  localparam int SY_RCOSC = 6;
  localparam int SY_INTERNAL_OSC_MODE = 7;
  typedef enum logic [2:0] {
    MODE_SLOW_XTAL = 3'h0,
    MODE_MED_XTAL = 3'h1,
    MODE_FAST_XTAL = 3'h2,
    MODE_DRIVEN = 3'h3,
    MODE_INT_IO = 3'h4,
    MODE_INT = 3'h5,
    MODE_RC_IO = 3'h6,
    MODE_RC = 3'h7
  } clk_mode_t;
  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_RUN = 3'b010,
    ST_PROG = 3'b100
  } st_t;
endpackage

// ===== design/quarter_divider.sv
`timescale 1ns/1ps
module quarter_divider
  import cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_level,
  input wire logic run,
  output logic q
);
  typedef struct packed {
    logic prev;
    logic [1:0] cnt;
  } div_t;

  div_t s_r;
  div_t s_nxt;

  // Two rising edges per half period gives the input rate over four
  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = clk_level;
    if (!run) begin
      s_nxt.cnt = 2'h0;
    end else if (clk_level && !s_r.prev) begin
      s_nxt.cnt = s_r.cnt + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.cnt[1];
endmodule

// ===== design/config_word_decode.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
// How it works
// - RC mode: quarter clock on output pin
// - RC I/O mode: output pin becomes I/O
// - Config words at 2007h/2008h, programming only
// - Bit 13 one: debugger off, pins I/O
// - Bit 12 picks 500 kHz or 16 MHz
// - Bit 10 picks brown-out trip level
// - Brown-out policy: off, run-only, always
// - Brown-out does not enable power-up delay
// - Bit 6 zero turns readout lock on
// - Unlocking readout erases program memory
// - Bit 5 selects reset pin or input
// - Reset pin stops internal/RC oscillator
// - Bit 4 zero enables power-up delay
// - Bit 3 one enables watchdog
// - Clock codes 111 to 100 decoded
// - Clock codes 011 to 000 decoded
// - Word one bits 11, 7 read one
// - Capacitor pin chosen by two bits
// - Low-voltage variant disables capacitor pins
// - Word two unimplemented bits read one
// - Trim clears on power-on; divider loads 10
module config_word_decode
  import cfg_pkg::*;
#(
  parameter bit LOW_VOLTAGE = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dev_reset_req,
  input wire logic dev_reset_por,
  input wire logic hard_reset_pin_n,
  input wire logic sleep_req,
  input wire logic osc_locked,
  input wire logic osc_stable,
  input wire logic rc_osc_in,
  input wire logic int_osc_in,
  output logic [2:0] clk_mode,
  output logic fast_internal_osc_flag,
  output logic [1:0] internal_osc_divider_field,
  output logic [5:0] internal_osc_trim,
  output logic brownout_level_flag,
  output logic brownout_reset_en,
  output logic powerup_delay_timer_en,
  output logic watchdog_timer_en,
  output logic readout_lock,
  output logic hard_reset_pin_flag,
  output logic internal_reset,
  output logic pin_digital_in,
  output logic debugger_en,
  output logic [2:0] regulator_cap_pin_sel,
  output logic osc_in_gpio,
  output logic osc_out_gpio,
  output logic osc_stop,
  output logic program_erase,
  output logic prog_mode,
  output logic quarter_clock_output
);
  typedef struct packed {
    st_t st;
    logic [15:0] cfg1;
    logic [15:0] cfg2;
    logic [1:0] osc_div;
    logic [5:0] osc_trim;
    logic prog_en;
    logic [SYNC_N-1:0] s1;
    logic [SYNC_N-1:0] s2;
    clk_mode_t mode;
    logic fast;
    logic bor_low;
    logic bor_run;
    logic bor_sleep;
    logic bor_active;
    logic pwrup_en;
    logic wdt_en;
    logic lock;
    logic hard_reset_pin_en;
    logic dbg_en;
    logic [2:0] cap_sel;
    logic osc_in_io;
    logic osc_out_io;
    logic quarter_clock_output_en;
    logic osc_stop;
    logic ext_reset;
    logic pin_din;
    logic erase;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic div_q;

  wire logic [15:0] idx = paddr[ADDR_W-1:2];
  wire logic setup = psel && !penable;
  wire logic wr_go = psel && penable && pwrite && st_r.pready && !st_r.pslverr;
  wire logic is_cfg = (idx == IDX_CFG_ONE) || (idx == IDX_CFG_TWO);
  wire logic is_mapped = is_cfg || (idx == IDX_OSC_CTRL) || (idx == IDX_OSC_TRIM) ||
                         (idx == IDX_PROG_CTRL) || (idx == IDX_SETTINGS);
  wire logic pin_low = !st_r.s2[SY_PIN];

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = {int_osc_in, rc_osc_in, osc_stable, osc_locked,
                 sleep_req, hard_reset_pin_n, dev_reset_por, dev_reset_req};
    st_nxt.s2 = st_r.s1;
    st_nxt.erase = 1'b0;

    // Zero wait state: answer is ready one edge after the setup cycle
    st_nxt.pready = setup;
    st_nxt.pslverr = setup && (!is_mapped || (is_cfg && st_r.st != ST_PROG));
    st_nxt.prdata = 32'h0000_0000;
    if (setup && !pwrite && st_r.st == ST_PROG && idx == IDX_CFG_ONE) begin
      st_nxt.prdata = {16'h0000, (st_r.cfg1 | CFG_ONE_FORCE1) & CFG_IMPL_MASK};
    end else if (setup && !pwrite && st_r.st == ST_PROG && idx == IDX_CFG_TWO) begin
      st_nxt.prdata = {16'h0000, (st_r.cfg2 | CFG_TWO_FORCE1) & CFG_IMPL_MASK};
    end else if (setup && !pwrite && idx == IDX_OSC_CTRL) begin
      st_nxt.prdata[DIV_HI:DIV_LO] = st_r.osc_div;
      st_nxt.prdata[LOCKED_BIT] = st_r.s2[SY_LOCK];
      st_nxt.prdata[STABLE_BIT] = st_r.s2[SY_STAB];
    end else if (setup && !pwrite && idx == IDX_OSC_TRIM) begin
      st_nxt.prdata = {26'h0000000, st_r.osc_trim};
    end else if (setup && !pwrite && idx == IDX_PROG_CTRL) begin
      st_nxt.prdata[PROG_EN_BIT] = st_r.prog_en;
    end else if (setup && !pwrite && idx == IDX_SETTINGS) begin
      st_nxt.prdata = {13'h0000, st_r.st, st_r.osc_stop, st_r.cap_sel, st_r.dbg_en,
                       st_r.hard_reset_pin_en, st_r.lock, st_r.wdt_en, st_r.pwrup_en,
                       st_r.bor_sleep, st_r.bor_run, st_r.bor_low, st_r.fast, st_r.mode};
    end

    if (wr_go) begin
      case (idx)
        IDX_CFG_ONE: begin
          st_nxt.cfg1 = pwdata[15:0];
          // Lifting the lock wipes program memory before it can be read
          st_nxt.erase = !st_r.cfg1[LOCK_BIT] && pwdata[LOCK_BIT];
        end
        IDX_CFG_TWO: st_nxt.cfg2 = pwdata[15:0];
        IDX_OSC_CTRL: st_nxt.osc_div = pwdata[DIV_HI:DIV_LO];
        IDX_OSC_TRIM: st_nxt.osc_trim = pwdata[5:0];
        IDX_PROG_CTRL: st_nxt.prog_en = pwdata[PROG_EN_BIT];
        default: st_nxt.prog_en = st_r.prog_en;
      endcase
    end

    // Device reset beats a same-cycle divider write, and a trim write only on power-on
    if (st_r.s2[SY_RST]) begin
      st_nxt.osc_div = OSC_DIV_RST;
      if (st_r.s2[SY_POR]) begin
        st_nxt.osc_trim = OSC_TRIM_RST;
      end
    end

    case (st_r.st)
      ST_LOAD: begin
        if (!st_r.s2[SY_RST]) begin
          st_nxt.st = st_r.prog_en ? ST_PROG : ST_RUN;
        end
      end
      ST_RUN: begin
        if (st_r.s2[SY_RST]) begin
          st_nxt.st = ST_LOAD;
        end else if (st_r.prog_en) begin
          st_nxt.st = ST_PROG;
        end
      end
      ST_PROG: begin
        if (!st_r.prog_en) begin
          st_nxt.st = ST_LOAD;
        end
      end
      default: st_nxt.st = ST_LOAD;
    endcase

    // Settings follow the words only while loading, so a write in
    // programming mode takes hold only once programming mode is left
    if (st_r.st == ST_LOAD) begin
      st_nxt.mode = clk_mode_t'(st_r.cfg1[2:0]);
      st_nxt.dbg_en = !st_r.cfg1[DBG_BIT];
      st_nxt.fast = st_r.cfg1[FAST_BIT];
      st_nxt.bor_low = st_r.cfg1[BROWNOUT_LEVEL_FLAG_BIT];
      st_nxt.bor_run = st_r.cfg1[BROWNOUT_POLICY_FIELD_HI];
      st_nxt.bor_sleep = st_r.cfg1[BROWNOUT_POLICY_FIELD_HI] && st_r.cfg1[BROWNOUT_POLICY_FIELD_LO];
      st_nxt.lock = !st_r.cfg1[LOCK_BIT];
      st_nxt.hard_reset_pin_en = st_r.cfg1[HARD_RESET_PIN_BIT];
      st_nxt.pwrup_en = !st_r.cfg1[POWERUP_DELAY_TIMER_BIT];
      st_nxt.wdt_en = st_r.cfg1[WDT_BIT];
      if (LOW_VOLTAGE) begin
        st_nxt.cap_sel = 3'h0;
      end else begin
        case (st_r.cfg2[CAP_HI:CAP_LO])
          2'h0: st_nxt.cap_sel = 3'h1;
          2'h1: st_nxt.cap_sel = 3'h2;
          2'h2: st_nxt.cap_sel = 3'h4;
          default: st_nxt.cap_sel = 3'h0;
        endcase
      end
    end

    case (st_r.mode)
      MODE_RC: begin
        st_nxt.osc_in_io = 1'b0;
        st_nxt.osc_out_io = 1'b0;
        st_nxt.quarter_clock_output_en = 1'b1;
      end
      MODE_RC_IO: begin
        st_nxt.osc_in_io = 1'b0;
        st_nxt.osc_out_io = 1'b1;
        st_nxt.quarter_clock_output_en = 1'b0;
      end
      MODE_INT: begin
        st_nxt.osc_in_io = 1'b1;
        st_nxt.osc_out_io = 1'b0;
        st_nxt.quarter_clock_output_en = 1'b1;
      end
      MODE_INT_IO: begin
        st_nxt.osc_in_io = 1'b1;
        st_nxt.osc_out_io = 1'b1;
        st_nxt.quarter_clock_output_en = 1'b0;
      end
      MODE_DRIVEN: begin
        st_nxt.osc_in_io = 1'b0;
        st_nxt.osc_out_io = 1'b1;
        st_nxt.quarter_clock_output_en = 1'b0;
      end
      default: begin
        st_nxt.osc_in_io = 1'b0;
        st_nxt.osc_out_io = 1'b0;
        st_nxt.quarter_clock_output_en = 1'b0;
      end
    endcase

    st_nxt.bor_active = st_r.bor_run && (st_r.bor_sleep || !st_r.s2[SY_SLEEP]);
    st_nxt.ext_reset = st_nxt.hard_reset_pin_en && pin_low;
    st_nxt.pin_din = !st_nxt.hard_reset_pin_en && st_r.s2[SY_PIN];
    st_nxt.osc_stop = st_r.hard_reset_pin_en && pin_low && st_r.mode[2];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.st <= ST_LOAD;
      st_r.cfg1 <= CFG_ONE_RST;
      st_r.cfg2 <= CFG_TWO_RST;
      st_r.osc_div <= OSC_DIV_RST;
      st_r.osc_trim <= OSC_TRIM_RST;
      st_r.mode <= MODE_SLOW_XTAL;
      st_r.s1[SY_PIN] <= 1'b1; // Pin idles high, so no fake reset-pin pulse
      st_r.s2[SY_PIN] <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Internal source divided while internal, RC pin otherwise
  quarter_divider u_quarter (
    .pclk(pclk),
    .presetn(presetn),
    .clk_level(st_r.mode == MODE_INT ? st_r.s2[SY_INTERNAL_OSC_MODE] : st_r.s2[SY_RCOSC]),
    .run(st_r.quarter_clock_output_en && !st_r.osc_stop),
    .q(div_q)
  );

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign clk_mode = st_r.mode;
  assign fast_internal_osc_flag = st_r.fast;
  assign internal_osc_divider_field = st_r.osc_div;
  assign internal_osc_trim = st_r.osc_trim;
  assign brownout_level_flag = st_r.bor_low;
  assign brownout_reset_en = st_r.bor_active;
  assign powerup_delay_timer_en = st_r.pwrup_en;
  assign watchdog_timer_en = st_r.wdt_en;
  assign readout_lock = st_r.lock;
  assign hard_reset_pin_flag = st_r.hard_reset_pin_en;
  assign internal_reset = st_r.ext_reset;
  assign pin_digital_in = st_r.pin_din;
  assign debugger_en = st_r.dbg_en;
  assign regulator_cap_pin_sel = st_r.cap_sel;
  assign osc_in_gpio = st_r.osc_in_io;
  assign osc_out_gpio = st_r.osc_out_io;
  assign osc_stop = st_r.osc_stop;
  assign program_erase = st_r.erase;
  assign prog_mode = st_r.st[2];
  assign quarter_clock_output = div_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_held;
    (st_r.st == ST_RUN && $past(st_r.st) == ST_RUN) |->
      $stable({st_r.mode, st_r.wdt_en, st_r.lock, st_r.cap_sel});
  endproperty
  a_held: assert property (p_held) else $error("settings moved while running");

  property p_cfg_gate;
    (setup && is_cfg && st_r.st != ST_PROG) |=> (pready && pslverr);
  endproperty
  a_cfg_gate: assert property (p_cfg_gate) else $error("config word reachable");

  property p_one_force;
    (setup && !pwrite && idx == IDX_CFG_ONE && st_r.st == ST_PROG) |=>
      (prdata[11] && prdata[7] && !pslverr);
  endproperty
  a_one_force: assert property (p_one_force) else $error("word one bits 11/7 low");

  property p_two_force;
    (setup && !pwrite && idx == IDX_CFG_TWO && st_r.st == ST_PROG) |=>
      (prdata[13:6] == 8'hff && prdata[3:0] == 4'hf);
  endproperty
  a_two_force: assert property (p_two_force) else $error("word two pad bits low");

  property p_wdt;
    st_r.st == ST_LOAD |=> watchdog_timer_en == $past(st_r.cfg1[WDT_BIT]);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog not from bit 3");

  property p_bor;
    (st_r.st == ST_LOAD && st_r.cfg1[BROWNOUT_POLICY_FIELD_HI:BROWNOUT_POLICY_FIELD_LO] == 2'h2) ##1 st_r.s2[SY_SLEEP]
      |=> !brownout_reset_en;
  endproperty
  a_bor: assert property (p_bor) else $error("brown-out on in sleep");

  property p_stop;
    (pin_low && st_r.hard_reset_pin_en && st_r.mode >= MODE_INT_IO) |=> osc_stop;
  endproperty
  a_stop: assert property (p_stop) else $error("oscillator not stopped");

  property p_trim;
    (st_r.s2[SY_RST] && st_r.s2[SY_POR]) |=>
      (internal_osc_trim == OSC_TRIM_RST && internal_osc_divider_field == OSC_DIV_RST);
  endproperty
  a_trim: assert property (p_trim) else $error("reset values not loaded");
  property p_erase;
    program_erase |=> !program_erase;
  endproperty
  a_erase: assert property (p_erase) else $error("erase pulse too long");
  property p_lv;
    LOW_VOLTAGE |-> regulator_cap_pin_sel == 3'h0;
  endproperty
  a_lv: assert property (p_lv) else $error("capacitor pin on low-voltage part");
  property p_rc;
    st_r.mode == MODE_RC |=> !osc_out_gpio && !osc_in_gpio;
  endproperty
  a_rc: assert property (p_rc) else $error("RC pins wrong");
  property p_hard_reset_pin;
    !hard_reset_pin_flag |-> !internal_reset;
  endproperty
  a_hard_reset_pin: assert property (p_hard_reset_pin) else $error("reset line active with pin as input");

  c_prog: cover property (st_r.st == ST_RUN ##1 st_r.st == ST_PROG);
  c_erase: cover property (program_erase);
  c_stop: cover property (osc_stop);
  c_quarter_clock_output: cover property ($rose(quarter_clock_output));
endmodule

// ===== testbench/prog_model.sv
`timescale 1ns/1ps
module prog_model
  import cfg_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end

  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines carry junk, not the last value
    paddr <= ~paddr;
    pwdata <= ~pwdata;
    @(posedge pclk);
  endtask

  // Words only touched inside a programming session
  task automatic burn(input logic [15:0] w1, input logic [15:0] w2);
    logic [31:0] r;
    logic e;
    xfer(1'b1, IDX_PROG_CTRL, 32'h1, r, e);
    xfer(1'b1, IDX_CFG_ONE, {16'h0000, w1}, r, e);
    xfer(1'b1, IDX_CFG_TWO, {16'h0000, w2}, r, e);
  endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench
  import cfg_pkg::*;
;
  logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, r, seed = 32'h5c;
  logic dev_reset_req, dev_reset_por, hard_reset_pin_n, sleep_req, osc_locked, osc_stable;
  logic rc_osc_in, int_osc_in, fast_internal_osc_flag, brownout_level_flag, brownout_reset_en;
  logic powerup_delay_timer_en, watchdog_timer_en, readout_lock, hard_reset_pin_flag, e;
  logic internal_reset, pin_digital_in, debugger_en, osc_in_gpio, osc_out_gpio, osc_stop;
  logic program_erase, prog_mode, quarter_clock_output, qprev;
  logic [2:0] clk_mode, regulator_cap_pin_sel, lv_cap_sel;
  logic [1:0] internal_osc_divider_field;
  logic [5:0] internal_osc_trim, t;
  int fails = 0, checks = 0, erases = 0, exp_erase = 0, w1, w2, old1, m, q;

  config_word_decode uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dev_reset_req(dev_reset_req), .dev_reset_por(dev_reset_por),
    .hard_reset_pin_n(hard_reset_pin_n), .sleep_req(sleep_req), .osc_locked(osc_locked),
    .osc_stable(osc_stable), .rc_osc_in(rc_osc_in), .int_osc_in(int_osc_in),
    .clk_mode(clk_mode), .fast_internal_osc_flag(fast_internal_osc_flag),
    .internal_osc_divider_field(internal_osc_divider_field),
    .internal_osc_trim(internal_osc_trim), .brownout_level_flag(brownout_level_flag),
    .brownout_reset_en(brownout_reset_en), .powerup_delay_timer_en(powerup_delay_timer_en),
    .watchdog_timer_en(watchdog_timer_en), .readout_lock(readout_lock),
    .hard_reset_pin_flag(hard_reset_pin_flag), .internal_reset(internal_reset),
    .pin_digital_in(pin_digital_in), .debugger_en(debugger_en),
    .regulator_cap_pin_sel(regulator_cap_pin_sel), .osc_in_gpio(osc_in_gpio),
    .osc_out_gpio(osc_out_gpio), .osc_stop(osc_stop), .program_erase(program_erase),
    .prog_mode(prog_mode), .quarter_clock_output(quarter_clock_output));

  prog_model prog (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Low-voltage variant beside the main one, same stimulus
  config_word_decode #(.LOW_VOLTAGE(1'b1)) uut_lv (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(), .pready(), .pslverr(), .dev_reset_req(dev_reset_req),
    .dev_reset_por(dev_reset_por), .hard_reset_pin_n(hard_reset_pin_n), .sleep_req(sleep_req),
    .osc_locked(osc_locked), .osc_stable(osc_stable), .rc_osc_in(rc_osc_in),
    .int_osc_in(int_osc_in), .clk_mode(), .fast_internal_osc_flag(),
    .internal_osc_divider_field(), .internal_osc_trim(), .brownout_level_flag(),
    .brownout_reset_en(), .powerup_delay_timer_en(), .watchdog_timer_en(), .readout_lock(),
    .hard_reset_pin_flag(), .internal_reset(), .pin_digital_in(), .debugger_en(),
    .regulator_cap_pin_sel(lv_cap_sel), .osc_in_gpio(), .osc_out_gpio(), .osc_stop(),
    .program_erase(), .prog_mode(), .quarter_clock_output());

  always #2 pclk = ~pclk;

  always @(posedge pclk) begin
    rc_osc_in <= ~rc_osc_in;
    int_osc_in <= ~int_osc_in;
    if (program_erase === 1'b1) begin
      erases++;
    end
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task tally_and_finish();
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Reference decode, worked out bit by bit from the words
  task check_cfg();
    m = w1 & 7;
    chk(clk_mode, m, "mode");
    chk(fast_internal_osc_flag, (w1 >> 12) & 1, "fast");
    chk(brownout_level_flag, (w1 >> 10) & 1, "level");
    chk(brownout_reset_en, w1[9] && (w1[8] || !sleep_req), "bor");
    chk(powerup_delay_timer_en, !w1[4], "pwrup");
    chk(watchdog_timer_en, w1[3], "wdt");
    chk(readout_lock, !w1[6], "lock");
    chk(hard_reset_pin_flag, w1[5], "pinflag");
    chk(debugger_en, !w1[13], "dbg");
    chk(regulator_cap_pin_sel, (w2[5:4] == 3) ? 0 : 1 << w2[5:4], "cap");
    chk(lv_cap_sel, 0, "lv cap");
    chk(osc_out_gpio, m == 6 || m == 4 || m == 3, "outio");
    chk(osc_in_gpio, m == 5 || m == 4, "inio");
    q = 0;
    qprev = 1'b1;
    repeat (64) begin
      @(posedge pclk);
      if (quarter_clock_output === 1'b1 && qprev === 1'b0) q++;
      qprev = quarter_clock_output;
    end
    chk((m == 7 || m == 5) ? (q >= 7 && q <= 9) : q == 0, 1, "quarter_clock_output");
    hard_reset_pin_n <= 1'b0;
    repeat (5) @(posedge pclk);
    chk(internal_reset, w1[5], "intrst");
    chk(osc_stop, w1[5] && m >= 4, "oscstop");
    chk(pin_digital_in, 0, "pinlow");
    hard_reset_pin_n <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(pin_digital_in, !w1[5], "pinhigh");
    chk(internal_reset, 0, "intrel");
  endtask

  initial begin
    {presetn, dev_reset_req, dev_reset_por, sleep_req, osc_locked, osc_stable} = '0;
    {rc_osc_in, int_osc_in} = '0;
    hard_reset_pin_n = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    w1 = 32'h3fff;
    w2 = 32'h3fff;
    old1 = w1;
    prog.xfer(1'b1, IDX_CFG_ONE, 32'h0, r, e);
    chk(e, 1, "wr locked");
    prog.xfer(1'b0, IDX_CFG_ONE, 32'h0, r, e);
    chk(r, 32'h0, "rd locked data");
    chk(e, 1, "rd locked");
    prog.xfer(1'b0, 16'h0100, 32'h0, r, e);
    chk(e, 1, "unmapped");
    check_cfg();
    chk(internal_osc_divider_field, 2, "div rst");
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      w1 = (rnd() & 32'h3fb8) | i | ((i & 1) << 6);
      w2 = rnd() & 32'h3fff;
      sleep_req <= 1'(rnd() & 1);
      if (!old1[6] && w1[6]) exp_erase++;
      prog.burn(w1[15:0], w2[15:0]);
      chk(prog_mode, 1, "prog");
      chk(clk_mode, old1 & 7, "held");
      prog.xfer(1'b0, IDX_CFG_ONE, 32'h0, r, e);
      chk(r, (w1 | 32'h0880) & 32'h3fff, "word one");
      prog.xfer(1'b0, IDX_CFG_TWO, 32'h0, r, e);
      chk(r, (w2 | 32'h3fcf) & 32'h3fff, "word two");
      prog.xfer(1'b1, IDX_PROG_CTRL, 32'h0, r, e);
      repeat (6) @(posedge pclk);
      check_cfg();
      old1 = w1;
    end
    chk(erases, exp_erase, "erase");
    $display("test words done");
    for (int p = 0; p < 2; p++) begin
      t = 6'(rnd());
      osc_locked <= 1'(p);
      osc_stable <= !p;
      prog.xfer(1'b1, IDX_OSC_TRIM, {26'h0, t}, r, e);
      prog.xfer(1'b1, IDX_OSC_CTRL, 32'h0, r, e);
      prog.xfer(1'b0, IDX_OSC_CTRL, 32'h0, r, e);
      chk(r, (p << 3) | ((1 - p) << 2), "ctrl");
      dev_reset_req <= 1'b1;
      dev_reset_por <= 1'(p);
      repeat (6) @(posedge pclk);
      dev_reset_req <= 1'b0;
      dev_reset_por <= 1'b0;
      repeat (6) @(posedge pclk);
      chk(internal_osc_divider_field, 2, "div");
      prog.xfer(1'b0, IDX_OSC_TRIM, 32'h0, r, e);
      chk(r, p ? 0 : t, "trim");
      chk(internal_osc_trim, p ? 0 : t, "trim out");
    end
    $display("test resets done");
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    $display("ERROR t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
